/* File: aicc_bch_path.sv */
// B-channel datapath between the line side and the TDM serial port.
// Assumes byte-wide channel samples that are valid on every clock.
module aicc_bch_path
   import aicc_pkg::*;
(
   input wire logic core_clk, // 50 MHz core clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic cust_en, // Transparent 2B+D passing allowed.
   input wire logic block_b1, // Block first port timeslot.
   input wire logic block_b2, // Block second port timeslot.
   input wire logic swap, // Exchange B1 and B2 in both directions.
   input wire logic serial_invert, // Port data is inverted.
   input wire logic [7:0] line_b1_rx, // B1 byte from the line.
   input wire logic [7:0] line_b2_rx, // B2 byte from the line.
   input wire logic [7:0] port_b1_rx, // First timeslot byte from port.
   input wire logic [7:0] port_b2_rx, // Second timeslot byte from port.
   output logic [7:0] port_b1_tx, // First timeslot byte to port.
   output logic [7:0] port_b2_tx, // Second timeslot byte to port.
   output logic [7:0] line_b1_tx, // B1 byte to the line.
   output logic [7:0] line_b2_tx // B2 byte to the line.
);

   typedef struct packed {
      logic [1:0][7:0] port_tx;
      logic [1:0][7:0] line_tx;
   } aicc_bch_state_t;

   aicc_bch_state_t s;
   aicc_bch_state_t next_s;
   logic [1:0][7:0] line_rx;
   logic [1:0][7:0] port_rx;
   logic [1:0][7:0] to_port;
   logic [1:0][7:0] to_line;
   logic [1:0] blocked;

   // Checks in this module sample on core_clk and rest during reset.
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   assign line_rx = {line_b2_rx, line_b1_rx};
   assign port_rx = {port_b2_rx, port_b1_rx};
   assign blocked = {block_b2, block_b1};

   // Per channel: the swap picks the source, then blocking applies to the
   // port timeslot, so the block always names the port slot, not the line.
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      always_comb begin
         if (!cust_en) begin
            to_port[ch] = AICC_IDLE_BYTE;
            to_line[ch] = AICC_IDLE_BYTE;
         end else begin
            to_port[ch] = swap ? line_rx[1-ch] : line_rx[ch]; // RULE23
            to_line[ch] = swap ? port_rx[1-ch] : port_rx[ch]; // RULE23
            if (blocked[ch]) begin
               to_port[ch] = serial_invert ? 8'h00 : 8'hFF; // RULE21 RULE22
            end
         end
      end
   end

   // Customer enable gates the whole path; blocked slots still reach line.
   always_comb begin
      next_s.port_tx = to_port; // RULE12
      next_s.line_tx = to_line;
   end

   // All path state registered on every clock.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s <= '{port_tx: {2{AICC_IDLE_BYTE}}, line_tx: {2{AICC_IDLE_BYTE}}};
      end else begin
         s <= next_s;
      end
   end

   assign port_b1_tx = s.port_tx[0];
   assign port_b2_tx = s.port_tx[1];
   assign line_b1_tx = s.line_tx[0];
   assign line_b2_tx = s.line_tx[1];

   AST_BLOCK_B1: assert property ( // RULE21
      cust_en && block_b1 |=>
      port_b1_tx == ($past(serial_invert) ? 8'h00 : 8'hFF))
      else $error("Blocked first timeslot did not carry the idle pattern.");

   AST_BLOCK_FWD: assert property ( // RULE22
      cust_en && block_b2 && !swap |=> line_b2_tx == $past(port_b2_rx))
      else $error("Blocked second timeslot was not forwarded to the line.");

   AST_SWAP: assert property ( // RULE23
      cust_en && swap && !block_b1 |=> port_b1_tx == $past(line_b2_rx))
      else $error("Swap did not exchange the B channels toward the port.");

endmodule : aicc_bch_path

/* File: aicc_mcu_model.sv */
// Avalon-MM master that stands in for the microcontroller at the port.
// Assumes the slave answers through waitrequest; it waits as long as needed.
module aicc_mcu_model
   import aicc_pkg::*;
(
   input wire logic core_clk, // Core clock.
   input wire logic avs_waitrequest, // Slave wait.
   output logic [2:0] avs_address, // Word address.
   output logic avs_read, // Read request.
   output logic avs_write, // Write request.
   output logic [31:0] avs_writedata // Write data, nibble in 3:0.
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus from time zero.
   initial begin
      avs_address = 3'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
   end

   // One bus cycle, entered at a rising edge; the request is held until
   // waitrequest is sampled low, since the slave may stretch the answer.
   task automatic access(input logic rd, input logic [2:0] a,
                         input logic [3:0] d);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= ~rd;
      avs_writedata <= 32'(d);
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : access
endmodule : aicc_mcu_model

/* File: aicc_pkg.sv */
// Package of the activation, interrupt and B-channel control block.
// Assumes a single 50 MHz core clock and Avalon-MM word addressing.
package aicc_pkg;

   // Register word addresses on the Avalon-MM slave port.
   localparam logic [2:0] AICC_OFS_ACT_CTRL = 3'h2;
   localparam logic [2:0] AICC_OFS_IRQ_STAT = 3'h3;
   localparam logic [2:0] AICC_OFS_IRQ_MASK = 3'h4;
   localparam logic [2:0] AICC_OFS_BCH_CTRL = 3'h5;

   // Activation control field positions.
   localparam int AICC_ACT_REQ_BIT = 3;
   localparam int AICC_DEA_REQ_BIT = 2;
   localparam int AICC_UPD_DIS_BIT = 1;
   localparam int AICC_CUST_EN_BIT = 0;

   // Interrupt status and mask field positions, highest priority first.
   localparam int AICC_IRQ_ACT_BIT = 3;
   localparam int AICC_IRQ_OPS_BIT = 2;
   localparam int AICC_IRQ_MNT_BIT = 1;
   localparam int AICC_IRQ_SPR_BIT = 0;

   // B-channel port control field positions.
   localparam int AICC_BCH_BLK1_BIT = 2;
   localparam int AICC_BCH_BLK2_BIT = 1;
   localparam int AICC_BCH_SWAP_BIT = 0;

   // Reset values: control and status nibbles clear; transmitted M4 and spare bits reset to all ones.
   localparam logic [3:0] AICC_NIBBLE_RST = 4'h0;
   localparam logic [7:0] AICC_M4_TX_RST = 8'hFF;
   localparam logic [3:0] AICC_SPARE_TX_RST = 4'hF;
   localparam logic [7:0] AICC_IDLE_BYTE = 8'hFF;

   // Superframes sent before an LT deactivation halts transmission.
   localparam logic [1:0] AICC_DEA_SF_COUNT = 2'h3;

   // LT deactivation sequencer states.
   typedef enum logic [2:0] {
      AICC_DEA_IDLE = 3'b001,
      AICC_DEA_COUNT = 3'b010,
      AICC_DEA_HALT = 3'b100
   } aicc_dea_t;

endpackage : aicc_pkg

/* File: aicc_regs.sv */
// Control and status nibble registers of the U-interface transceiver,
// reached over an Avalon-MM slave with waitrequest.
// Assumes all status inputs and event pulses are synchronous to core_clk.
//
// How it works
// RULE1: activation request in full reset starts an activation attempt.
// RULE2: activation request self-clears on progress, LT wake pulse, reset.
// RULE3: a detected incoming wake tone starts activation in LT or NT mode.
// RULE4: LT linkup with deactivation request halts after three superframes.
// RULE5: clearing deactivation request before three superframes aborts it.
// RULE6: NT software sets deactivation request on received dea bit.
// RULE7: NT normal deactivation self-clears request and selects warm start.
// RULE8: in LT software clears deactivation request after deactivation.
// RULE9: update disable freezes transmitted M4, M50, M51, M60 at boundaries.
// RULE10: update disable leaves eoc, febe and crc bits untouched.
// RULE11: LT deactivation order: disable, write M4, enable, request.
// RULE12: customer enable passes 2B+D data transparently.
// RULE13: software keeps customer enable low until activation completes.
// RULE14: in GCI mode software writes both request bits as zero.
// RULE15: interrupt pin active while any status bit and its enable are set.
// RULE16: priority runs activation change, eoc, M4, spare bits.
// RULE17: activation change sets on status change, clears on status read.
// RULE18: eoc interrupt sets on buffer update, clears on buffer read.
// RULE19: M4 interrupt sets on receive buffer update, clears on its read.
// RULE20: spare-bits interrupt sets on buffer update, clears on its read.
// RULE21: block B1 sends idle pattern in the first port timeslot.
// RULE22: block B2 sends idle pattern in the second port timeslot.
// RULE23: swap exchanges the B channels in both directions.
// RULE24: interrupt pin is active low, OR of enabled pending bits.
//
// The Avalon-MM register port and the register addresses were decided locally.
module aicc_regs
   import aicc_pkg::*;
(
   input wire logic core_clk, // 50 MHz core clock.
   input wire logic rst_n, // Synchronous reset, active low.
   input wire logic [2:0] avs_address, // Avalon word address.
   input wire logic avs_read, // Avalon read request.
   input wire logic avs_write, // Avalon write request.
   input wire logic [31:0] avs_writedata, // Avalon write data.
   output logic [31:0] avs_readdata, // Avalon read data, registered.
   output logic avs_waitrequest, // Avalon wait, combinational.
   input wire logic mode_lt, // High in LT mode, low in NT mode.
   input wire logic full_reset_state, // Transceiver sits in full reset.
   input wire logic act_in_progress, // Activation in progress status.
   input wire logic wake_pulse_sent, // Pulse: wake pulse sent in LT.
   input wire logic wake_tone_detected, // Pulse: incoming wake tone.
   input wire logic linkup, // Full-duplex link established.
   input wire logic line_deactivated, // Pulse: transceiver deactivated.
   input wire logic sf_sync, // Received superframe in sync.
   input wire logic tx_sf_boundary, // Pulse: transmit superframe edge.
   input wire logic [7:0] maint_transmit_src, // Written M4 bits.
   input wire logic [3:0] spare_transmit_src, // Written M50/M51/M60 bits.
   input wire logic act_status_change, // Pulse: activation status moved.
   input wire logic act_status_read, // Pulse: status register read.
   input wire logic dchan_event, // Pulse: D-channel access event.
   input wire logic dchan_read, // Pulse: D-channel register read.
   input wire logic ops_buf_update, // Pulse: eoc buffer updated.
   input wire logic ops_buf_read, // Pulse: eoc buffer read.
   input wire logic maint_rx_update, // Pulse: M4 receive buffer updated.
   input wire logic maint_rx_read, // Pulse: M4 receive buffer read.
   input wire logic spare_rx_update, // Pulse: spare receive buffer updated.
   input wire logic spare_rx_read, // Pulse: spare receive buffer read.
   input wire logic serial_invert, // Serial port data inverted.
   input wire logic [7:0] line_b1_rx, // B1 byte from the line.
   input wire logic [7:0] line_b2_rx, // B2 byte from the line.
   input wire logic [7:0] port_b1_rx, // First timeslot byte from port.
   input wire logic [7:0] port_b2_rx, // Second timeslot byte from port.
   output logic activation_start, // Activation attempt requested.
   output logic warm_start, // Next activation uses warm start.
   output logic tx_halt, // LT deactivation: stop transmitting.
   output logic [7:0] maint_tx_bits, // M4 bits being transmitted.
   output logic [3:0] spare_tx_bits, // M50/M51/M60 bits being sent.
   output logic irq_n, // Interrupt pin, active low.
   output logic [1:0] irq_top, // Highest pending enabled source.
   output logic [7:0] port_b1_tx, // First timeslot byte to port.
   output logic [7:0] port_b2_tx, // Second timeslot byte to port.
   output logic [7:0] line_b1_tx, // B1 byte to the line.
   output logic [7:0] line_b2_tx // B2 byte to the line.
);

   typedef struct packed {
      logic [3:0] act_ctrl;
      logic [3:0] mask;
      logic [3:0] bch;
      logic act_pend;
      logic dchan_pend;
      logic ops_pend;
      logic maint_pend;
      logic spare_pend;
      logic ack;
      logic [31:0] rdata;
      logic prev_progress;
      aicc_dea_t dea;
      logic [1:0] sf_cnt;
      logic warm;
      logic start;
      logic [7:0] m4_tx;
      logic [3:0] spare_tx;
      logic irq_n;
      logic [1:0] irq_top;
   } aicc_state_t;

   localparam aicc_state_t AICC_STATE_RST = '{
      act_ctrl: AICC_NIBBLE_RST,
      mask: AICC_NIBBLE_RST,
      bch: AICC_NIBBLE_RST,
      act_pend: 1'b0,
      dchan_pend: 1'b0,
      ops_pend: 1'b0,
      maint_pend: 1'b0,
      spare_pend: 1'b0,
      ack: 1'b0,
      rdata: 32'h0000_0000,
      prev_progress: 1'b0,
      dea: AICC_DEA_IDLE,
      sf_cnt: 2'h0,
      warm: 1'b0,
      start: 1'b0,
      m4_tx: AICC_M4_TX_RST,
      spare_tx: AICC_SPARE_TX_RST,
      irq_n: 1'b1,
      irq_top: 2'h0
   };

   aicc_state_t s;
   aicc_state_t next_s;
   logic req;
   logic wr_act;
   logic [3:0] irq_stat;
   logic [3:0] next_stat;
   logic [3:0] next_active;

   // Checks in this module sample on core_clk and rest during reset.
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // The slave waits exactly one cycle; readdata is loaded in that cycle.
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~s.ack;
   assign wr_act = avs_write & s.ack & (avs_address == AICC_OFS_ACT_CTRL);
   assign irq_stat = {s.act_pend | s.dchan_pend, s.ops_pend, s.maint_pend,
      s.spare_pend};

   // Next-state logic for registers, flags, sequencer and outputs.
   always_comb begin
      next_s = s;
      next_stat = 4'h0;
      next_active = 4'h0;
      next_s.ack = req & ~s.ack;
      next_s.prev_progress = act_in_progress;

      // Read data are captured while waitrequest is high.
      if (req & ~s.ack) begin
         next_s.rdata = 32'h0000_0000;
         if (avs_read) begin
            unique case (avs_address)
               AICC_OFS_ACT_CTRL: next_s.rdata[3:0] = s.act_ctrl;
               AICC_OFS_IRQ_STAT: next_s.rdata[3:0] = irq_stat;
               AICC_OFS_IRQ_MASK: next_s.rdata[3:0] = s.mask;
               AICC_OFS_BCH_CTRL: next_s.rdata[3:0] = s.bch;
               default: next_s.rdata = 32'h0000_0000;
            endcase
         end
      end

      // Hardware clears of the request bits come first, so that a software
      // write in the same cycle takes precedence and is never lost.
      if ((act_in_progress & ~s.prev_progress) |
          (mode_lt & wake_pulse_sent)) begin
         next_s.act_ctrl[AICC_ACT_REQ_BIT] = 1'b0; // RULE2
      end
      if (!mode_lt && line_deactivated && s.act_ctrl[AICC_DEA_REQ_BIT]) begin
         next_s.act_ctrl[AICC_DEA_REQ_BIT] = 1'b0; // RULE7
         next_s.warm = 1'b1; // RULE7
      end else if (act_in_progress & ~s.prev_progress) begin
         next_s.warm = 1'b0;
      end

      // Register writes land on the edge where waitrequest is low.
      if (avs_write && s.ack) begin
         unique case (avs_address)
            AICC_OFS_ACT_CTRL: next_s.act_ctrl = avs_writedata[3:0];
            AICC_OFS_IRQ_MASK: next_s.mask = avs_writedata[3:0];
            AICC_OFS_BCH_CTRL: next_s.bch = avs_writedata[3:0];
            default: next_s.mask = s.mask;
         endcase
      end

      // Start request: software request in full reset, or a wake tone.
      next_s.start = (s.act_ctrl[AICC_ACT_REQ_BIT] & full_reset_state) // RULE1
         | wake_tone_detected; // RULE3

      // LT deactivation waits three transmitted superframes after linkup.
      unique case (s.dea)
         AICC_DEA_IDLE: begin
            next_s.sf_cnt = 2'h0;
            if (mode_lt && linkup && s.act_ctrl[AICC_DEA_REQ_BIT]) begin
               next_s.dea = AICC_DEA_COUNT; // RULE4
            end
         end
         AICC_DEA_COUNT: begin
            if (!mode_lt || !s.act_ctrl[AICC_DEA_REQ_BIT]) begin
               next_s.dea = AICC_DEA_IDLE; // RULE5
            end else if (tx_sf_boundary) begin
               if (s.sf_cnt == AICC_DEA_SF_COUNT - 2'h1) begin
                  next_s.dea = AICC_DEA_HALT; // RULE4
               end else begin
                  next_s.sf_cnt = s.sf_cnt + 2'h1;
               end
            end
         end
         AICC_DEA_HALT: begin
            // Software clears the request once the link is down.
            if (!mode_lt || !s.act_ctrl[AICC_DEA_REQ_BIT]) begin
               next_s.dea = AICC_DEA_IDLE; // RULE8
            end
         end
         default: next_s.dea = AICC_DEA_IDLE;
      endcase

      // Maintenance bits reload at the boundary only when not frozen.
      // Only M4 and spare bits are held here; eoc, febe and crc never are.
      if (tx_sf_boundary && !s.act_ctrl[AICC_UPD_DIS_BIT]) begin
         next_s.m4_tx = maint_transmit_src; // RULE9 RULE10
         next_s.spare_tx = spare_transmit_src; // RULE9
      end

      // Sticky interrupt flags: a set in the clearing cycle wins.
      if (act_status_read) next_s.act_pend = 1'b0;
      if (act_status_change) next_s.act_pend = 1'b1; // RULE17
      if (dchan_read) next_s.dchan_pend = 1'b0; // RULE17
      if (dchan_event) next_s.dchan_pend = 1'b1;
      if (ops_buf_read) next_s.ops_pend = 1'b0;
      if (ops_buf_update && sf_sync) next_s.ops_pend = 1'b1; // RULE18
      if (maint_rx_read) next_s.maint_pend = 1'b0;
      if (maint_rx_update && sf_sync) next_s.maint_pend = 1'b1; // RULE19
      if (spare_rx_read) next_s.spare_pend = 1'b0;
      if (spare_rx_update && sf_sync) next_s.spare_pend = 1'b1; // RULE20

      // Pin and priority track the next flags, so they align with them.
      next_stat = {next_s.act_pend | next_s.dchan_pend, next_s.ops_pend,
         next_s.maint_pend, next_s.spare_pend};
      next_active = next_stat & next_s.mask;
      next_s.irq_n = ~|next_active; // RULE15 RULE24
      if (next_active[AICC_IRQ_ACT_BIT]) begin
         next_s.irq_top = 2'h3; // RULE16
      end else if (next_active[AICC_IRQ_OPS_BIT]) begin
         next_s.irq_top = 2'h2;
      end else if (next_active[AICC_IRQ_MNT_BIT]) begin
         next_s.irq_top = 2'h1;
      end else begin
         next_s.irq_top = 2'h0;
      end
   end

   // All block state but the B-channel bytes of u_bch in one register.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s <= AICC_STATE_RST;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata = s.rdata;
   assign activation_start = s.start;
   assign warm_start = s.warm;
   assign tx_halt = (s.dea == AICC_DEA_HALT);
   assign maint_tx_bits = s.m4_tx;
   assign spare_tx_bits = s.spare_tx;
   assign irq_n = s.irq_n;
   assign irq_top = s.irq_top;

   // B-channel path steered by customer enable and the port control bits.
   aicc_bch_path u_bch (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .cust_en(s.act_ctrl[AICC_CUST_EN_BIT]),
      .block_b1(s.bch[AICC_BCH_BLK1_BIT]),
      .block_b2(s.bch[AICC_BCH_BLK2_BIT]),
      .swap(s.bch[AICC_BCH_SWAP_BIT]),
      .serial_invert(serial_invert),
      .line_b1_rx(line_b1_rx),
      .line_b2_rx(line_b2_rx),
      .port_b1_rx(port_b1_rx),
      .port_b2_rx(port_b2_rx),
      .port_b1_tx(port_b1_tx),
      .port_b2_tx(port_b2_tx),
      .line_b1_tx(line_b1_tx),
      .line_b2_tx(line_b2_tx)
   );

   AST_ACT_START: assert property ( // RULE1
      s.act_ctrl[AICC_ACT_REQ_BIT] && full_reset_state |=> activation_start)
      else $error("Activation request in full reset did not start.");

   AST_ACT_CLEAR: assert property ( // RULE2
      mode_lt && wake_pulse_sent && !wr_act |=> !s.act_ctrl[AICC_ACT_REQ_BIT])
      else $error("Activation request not cleared after wake pulse.");

   AST_WAKE_START: assert property ( // RULE3
      wake_tone_detected |=> activation_start)
      else $error("Wake tone did not start an activation.");

   AST_HALT_THIRD: assert property ( // RULE4
      s.dea == AICC_DEA_COUNT && s.sf_cnt == 2'h2 && tx_sf_boundary &&
      mode_lt && s.act_ctrl[AICC_DEA_REQ_BIT] |=> tx_halt)
      else $error("Transmission not halted after the third superframe.");

   AST_ABORT: assert property ( // RULE5
      s.dea == AICC_DEA_COUNT && !s.act_ctrl[AICC_DEA_REQ_BIT] |=>
      !tx_halt ##1 !tx_halt)
      else $error("Cleared deactivation request did not abort the halt.");

   AST_NT_CLEAR: assert property ( // RULE7
      !mode_lt && line_deactivated && s.act_ctrl[AICC_DEA_REQ_BIT] && !wr_act
      |=> !s.act_ctrl[AICC_DEA_REQ_BIT] && warm_start)
      else $error("NT deactivation kept its request or missed warm start.");

   AST_FROZEN: assert property ( // RULE9
      tx_sf_boundary && s.act_ctrl[AICC_UPD_DIS_BIT] |=>
      $stable(maint_tx_bits) && $stable(spare_tx_bits))
      else $error("Maintenance bits changed while updates were disabled.");

   AST_LOAD: assert property ( // RULE9
      tx_sf_boundary && !s.act_ctrl[AICC_UPD_DIS_BIT] |=>
      maint_tx_bits == $past(maint_transmit_src))
      else $error("Maintenance bits not loaded at the superframe boundary.");

   AST_IRQ_PIN: assert property ( // RULE15
      irq_n == !(|(irq_stat & s.mask)))
      else $error("Interrupt pin disagrees with enabled pending bits.");

   AST_OPS_SET: assert property ( // RULE18
      ops_buf_update && sf_sync |=> s.ops_pend)
      else $error("Eoc update did not set its interrupt flag.");

   AST_ACT_PEND: assert property ( // RULE17
      act_status_read && !act_status_change && !dchan_event && !s.dchan_pend
      |=> !irq_stat[AICC_IRQ_ACT_BIT])
      else $error("Activation change flag survived its status read.");

endmodule : aicc_regs

/* File: testbench.sv */
// Self-checking bench of the control block, driven through the MCU model.
// Assumes a 50 MHz core clock and a synchronous active-low reset.
module testbench
   import aicc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, rst_n = 1'b0, mode_lt = 1'b0, full_rst = 1'b0;
   logic in_prog = 1'b0, linkup = 1'b0, sf_sync = 1'b0, ser_inv = 1'b0;
   logic [13:0] ev = 14'h0000;
   logic [7:0] mtx = 8'hFF, lb1 = 8'h00, lb2 = 8'h00;
   logic [7:0] pb1 = 8'h00, pb2 = 8'h00, mbits, p1, p2, l1, l2;
   logic [3:0] stx = 4'hF, sbits;
   logic [2:0] avs_address;
   logic [1:0] irq_top;
   logic avs_read, avs_write, avs_waitrequest, irq_n, act_start, warm, halt;
   logic [31:0] avs_writedata, avs_readdata, q[$];
   int n_mismatch = 0, compares = 0;

   always #10 core_clk = ~core_clk;

   aicc_mcu_model i_mcu (.core_clk(core_clk),
      .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata));
   aicc_regs i_dut (.core_clk(core_clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .mode_lt(mode_lt), .full_reset_state(full_rst),
      .act_in_progress(in_prog), .wake_pulse_sent(ev[10]),
      .wake_tone_detected(ev[11]), .linkup(linkup),
      .line_deactivated(ev[12]), .sf_sync(sf_sync),
      .tx_sf_boundary(ev[13]), .maint_transmit_src(mtx),
      .spare_transmit_src(stx), .act_status_change(ev[0]),
      .act_status_read(ev[1]), .dchan_event(ev[2]), .dchan_read(ev[3]),
      .ops_buf_update(ev[4]), .ops_buf_read(ev[5]),
      .maint_rx_update(ev[6]), .maint_rx_read(ev[7]),
      .spare_rx_update(ev[8]), .spare_rx_read(ev[9]),
      .serial_invert(ser_inv), .line_b1_rx(lb1), .line_b2_rx(lb2),
      .port_b1_rx(pb1), .port_b2_rx(pb2), .activation_start(act_start),
      .warm_start(warm), .tx_halt(halt), .maint_tx_bits(mbits),
      .spare_tx_bits(sbits), .irq_n(irq_n), .irq_top(irq_top),
      .port_b1_tx(p1), .port_b2_tx(p2), .line_b1_tx(l1), .line_b2_tx(l2));

   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // The expected read value is queued before the request goes out.
   task automatic rd(input logic [2:0] a, input logic [31:0] e);
      @(posedge core_clk);
      q.push_back(e);
      i_mcu.access(1'b1, a, 4'h0);
   endtask : rd

   task automatic wr(input logic [2:0] a, input logic [3:0] d);
      @(posedge core_clk);
      i_mcu.access(1'b0, a, d);
   endtask : wr

   task automatic pulse(input int i);
      @(posedge core_clk);
      ev[i] <= 1'b1;
      @(posedge core_clk);
      ev[i] <= 1'b0;
   endtask : pulse

   // Lets registered outputs land before they are looked at.
   task automatic settle();
      @(posedge core_clk);
      @(negedge core_clk);
   endtask : settle

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop

   // Each completed read takes the oldest expectation off the queue.
   always @(posedge core_clk) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         chk("readdata", q.pop_front(), avs_readdata);
      end
   end

   // Watchdog: the sequence needs well under two thousand cycles.
   initial begin
      #200_000;
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      logic [3:0] m;
      void'($urandom(99706));
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int a = 0; a < 6; a++) rd(3'(a), 32'h0);
      m = 4'($urandom);
      wr(AICC_OFS_IRQ_MASK, m);
      rd(AICC_OFS_IRQ_MASK, 32'(m));
      $display("test registers done");
      wr(AICC_OFS_IRQ_MASK, 4'h6);
      sf_sync <= 1'b1;
      pulse(6);
      settle();
      chk("irq_n", 32'h0, irq_n);
      pulse(4);
      settle();
      chk("irq_top", 32'h2, irq_top);
      rd(AICC_OFS_IRQ_STAT, 32'h6);
      pulse(5);
      settle();
      chk("irq_top", 32'h1, irq_top);
      pulse(7);
      pulse(0);
      pulse(8);
      settle();
      chk("irq_n", 32'h1, irq_n);
      rd(AICC_OFS_IRQ_STAT, 32'h9);
      pulse(1);
      pulse(9);
      rd(AICC_OFS_IRQ_STAT, 32'h0);
      pulse(2);
      rd(AICC_OFS_IRQ_STAT, 32'h8);
      pulse(3);
      rd(AICC_OFS_IRQ_STAT, 32'h0);
      $display("test interrupts done");
      full_rst <= 1'b1;
      wr(AICC_OFS_ACT_CTRL, 4'h8);
      settle();
      chk("activation_start", 32'h1, act_start);
      @(posedge core_clk);
      in_prog <= 1'b1;
      full_rst <= 1'b0;
      rd(AICC_OFS_ACT_CTRL, 32'h0);
      @(posedge core_clk);
      mode_lt <= 1'b1;
      linkup <= 1'b1;
      // Disable, load M4, enable, then request deactivation.
      wr(AICC_OFS_ACT_CTRL, 4'h2);
      {mtx, stx} <= 12'($urandom);
      pulse(13);
      settle();
      chk("maint_tx_bits", 32'hFF, mbits);
      chk("spare_tx_bits", 32'hF, sbits);
      wr(AICC_OFS_ACT_CTRL, 4'h0);
      pulse(13);
      settle();
      chk("maint_tx_bits", 32'(mtx), mbits);
      chk("spare_tx_bits", 32'(stx), sbits);
      wr(AICC_OFS_ACT_CTRL, 4'h4);
      pulse(13);
      pulse(13);
      wr(AICC_OFS_ACT_CTRL, 4'h0);
      pulse(13);
      settle();
      chk("tx_halt", 32'h0, halt);
      wr(AICC_OFS_ACT_CTRL, 4'h4);
      pulse(13);
      pulse(13);
      settle();
      chk("tx_halt", 32'h0, halt);
      pulse(13);
      settle();
      chk("tx_halt", 32'h1, halt);
      rd(AICC_OFS_ACT_CTRL, 32'h4);
      $display("test deactivation done");
      // Customer data only after linkup.
      wr(AICC_OFS_ACT_CTRL, 4'h1);
      {lb1, lb2, pb1, pb2} <= $urandom;
      wr(AICC_OFS_BCH_CTRL, 4'h5);
      settle();
      chk("port_b1_tx", 32'hFF, p1);
      chk("port_b2_tx", 32'(lb1), p2);
      chk("line_b1_tx", 32'(pb2), l1);
      @(posedge core_clk);
      ser_inv <= 1'b1;
      wr(AICC_OFS_BCH_CTRL, 4'h2);
      settle();
      chk("port_b2_tx", 32'h0, p2);
      chk("port_b1_tx", 32'(lb1), p1);
      chk("line_b2_tx", 32'(pb2), l2);
      @(posedge core_clk);
      mode_lt <= 1'b0;
      wr(AICC_OFS_ACT_CTRL, 4'h4);
      pulse(12);
      settle();
      chk("warm_start", 32'h1, warm);
      rd(AICC_OFS_ACT_CTRL, 32'h0);
      pulse(11);
      @(negedge core_clk);
      chk("activation_start", 32'h1, act_start);
      @(posedge core_clk);
      mode_lt <= 1'b1;
      wr(AICC_OFS_ACT_CTRL, 4'h8);
      pulse(10);
      rd(AICC_OFS_ACT_CTRL, 32'h0);
      $display("test channels done");
      report_and_stop();
   end
endmodule : testbench
